/* rtl/pwas_core.v */
/*
 * pwm generator with two outputs, polarity select and auto-shutdown, with
 * an apb slave for its registers. assumes pclk is the system clock, ce low
 * means sleep, cmp_in and shdn_pin_n arrive asynchronously from pins.
 */
// The implementer's own choices: the register addresses and the APB slave port.
// Notes on behaviour
// - while asleep the timer holds its count, all state freezes and pins keep their level.
// - the pwm rate is derived from the system clock, so it scales with it.
// - any reset makes both pins inputs and returns every register to its reset value.
// - a two-bit polarity field picks active-high or active-low for each output.
// - the timer flag sets as the second pwm period begins.
// - status bit 7 reads 1 while the event status or condition is set; outputs stay in shutdown after it reads 0 until the next period start.
// - source 000/010 off, 001/011 comparator change, 100/110 pin low, 101/111 either.
// - shutdown state fields give 00 low, 01 high, 1x tri-state for outputs a and b.
// - the shutdown condition is a level and holds shutdown while it persists; the comparator condition here is a one-cycle change pulse.
// - writes to the status bit are ignored while the condition persists.
// - after the condition clears and pwm restarts, outputs resume at the next period start.
`timescale 1ns/1ps
`default_nettype none
`include "pwas_map.vh"
module pwas_core #(
    parameter AUTO_RESTART = 1
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        cmp_in,
    input  wire        shdn_pin_n,
    output wire        pwm_output_a_o,
    output wire        pwm_output_a_oe_n,
    output wire        pwm_output_b_o,
    output wire        pwm_output_b_oe_n
);
    // registers
    reg  [7:0] period_register;
    reg  [7:0] pwm_mode_control;
    reg  [7:0] duty_upper_bits;
    reg  [7:0] period_timer_control;
    reg        period_timer_flag;
    reg  [6:0] auto_shutdown_control;
    reg        shutdown_event_status;
    reg  [1:0] pin_direction_bit;
    // timer and pwm state
    reg  [9:0] period_timer_count;
    reg  [9:0] duty_latched;
    reg        pwm_level;
    reg        first_done;
    reg        cmp_prev;
    reg        pwm_restart;
    wire       cmp_s;
    wire       pin_s;
    wire       tick;
    wire       wr_en;
    wire       rd_en;
    wire       timer_on;
    wire       pwm_on;
    wire       period_end;
    wire       cmp_change;
    wire       cond_cmp;
    wire       cond_pin;
    wire       shdn_cond;
    wire       shdn_active;
    wire [2:0] src;
    wire       pol_a;
    wire       pol_b;
    wire [1:0] ss_a;
    wire [1:0] ss_b;
    reg        next_a;
    reg        next_b;
    reg        next_a_z;
    reg        next_b_z;

    // pins come from outside pclk, two flops each
    pwas_sync u_sync_cmp (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       (cmp_in),
        .q       (cmp_s)
    );
    pwas_sync u_sync_pin (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       (shdn_pin_n),
        .q       (pin_s)
    );

    // timer tick comes from the system clock through the prescaler
    pwas_prescale u_prescale (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .run     (timer_on),
        .ps      (period_timer_control[`PWAS_TCTRL_PS_HI:`PWAS_TCTRL_PS_LO]),
        .tick    (tick)
    );

    // apb decode: zero wait states, frozen bus answers wait while asleep
    assign pready  = ce;
    assign pslverr = 1'b0;
    assign wr_en   = psel && penable && pwrite && ce;
    assign rd_en   = psel && !pwrite;

    assign timer_on = period_timer_control[`PWAS_TCTRL_ON_BIT];
    assign pwm_on   = pwm_mode_control[`PWAS_MODE_EN_HI:`PWAS_MODE_EN_LO] == 2'b11;
    assign pol_a    = pwm_mode_control[`PWAS_MODE_POL_A];
    assign pol_b    = pwm_mode_control[`PWAS_MODE_POL_B];
    assign src      = auto_shutdown_control[`PWAS_SHDN_SRC_HI:`PWAS_SHDN_SRC_LO];
    assign ss_a     = auto_shutdown_control[`PWAS_SHDN_A_HI:`PWAS_SHDN_A_LO];
    assign ss_b     = auto_shutdown_control[`PWAS_SHDN_B_HI:`PWAS_SHDN_B_LO];

    // period boundary: the 10-bit count (8 bits + 2 quarter bits) reaches the period
    assign period_end = tick && (period_timer_count[9:2] == period_register)
                        && (period_timer_count[1:0] == 2'b11);

    // comparator change is a mismatch against the last seen level
    assign cmp_change = cmp_s ^ cmp_prev;
    assign cond_cmp   = src[0] && cmp_change;
    assign cond_pin   = src[2] && !pin_s;
    assign shdn_cond  = cond_cmp || cond_pin;
    // status shows shutdown from the very cycle the source asserts
    assign shdn_active = shutdown_event_status || shdn_cond;

    // previous comparator sample for the change detector
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cmp_prev <= 1'b0;
        else if (ce)
            cmp_prev <= cmp_s;
    end

    // register writes; all state waits while ce is low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_register      <= `PWAS_PERIOD_RESET;
            pwm_mode_control     <= `PWAS_MODE_RESET;
            duty_upper_bits      <= `PWAS_DUTY_RESET;
            period_timer_control <= `PWAS_TCTRL_RESET;
            pin_direction_bit    <= `PWAS_DIR_RESET;
            auto_shutdown_control[6:0] <= 7'h00;
        end else if (ce && wr_en) begin
            case (paddr)
                `PWAS_OFS_PERIOD: period_register      <= pwdata[7:0];
                `PWAS_OFS_MODE:   pwm_mode_control     <= {2'b00, pwdata[5:0]};
                `PWAS_OFS_DUTY:   duty_upper_bits      <= pwdata[7:0];
                `PWAS_OFS_TCTRL:  period_timer_control <= {5'h00, pwdata[2:0]};
                `PWAS_OFS_DIR:    pin_direction_bit    <= pwdata[1:0];
                `PWAS_OFS_SHDN:   auto_shutdown_control[6:0] <= pwdata[6:0];
                default: ;
            endcase
        end
    end

    // shutdown status: set wins, software clear only once the condition is gone;
    // kept in its own flop so the control fields have a single writer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            shutdown_event_status <= 1'b0;
        else if (ce) begin
            if (shdn_cond)
                shutdown_event_status <= 1'b1;
            else if (wr_en && paddr == `PWAS_OFS_SHDN)
                shutdown_event_status <= pwdata[`PWAS_SHDN_STATUS_BIT];
            else if (AUTO_RESTART != 0 && !src[0] && src[2] && pin_s)
                shutdown_event_status <= 1'b0;                      // automatic restart on pin release
        end
    end

    // restart pending: outputs stay in shutdown until the next period start
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pwm_restart <= 1'b0;
        else if (ce) begin
            if (shdn_active)
                pwm_restart <= 1'b1;
            else if (period_end)
                pwm_restart <= 1'b0;
        end
    end

    // period timer, duty latch at period start, first-cycle tracking
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_timer_count <= 10'h000;
            duty_latched       <= 10'h000;
            first_done         <= 1'b0;
        end else if (ce) begin
            if (!timer_on)
                first_done <= 1'b0;
            else if (period_end) begin
                period_timer_count <= 10'h000;
                duty_latched <= {duty_upper_bits,
                                 pwm_mode_control[`PWAS_MODE_DLOW_HI:`PWAS_MODE_DLOW_LO]};
                first_done <= 1'b1;
            end else if (tick)
                period_timer_count <= period_timer_count + 10'h001;
        end
    end

    // timer flag: sets at every period start after the first, so the
    // earliest set marks the start of the second period
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            period_timer_flag <= 1'b0;
        else if (ce) begin
            if (period_end && first_done)
                period_timer_flag <= 1'b1;
            else if (wr_en && paddr == `PWAS_OFS_FLAGS)
                period_timer_flag <= pwdata[0];
        end
    end

    // raw active level of the pwm wave
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pwm_level <= 1'b0;
        else if (ce) begin
            if (!pwm_on || !timer_on)
                pwm_level <= 1'b0;
            else if (period_end)
                pwm_level <= (duty_upper_bits != 8'h00) ||
                             (pwm_mode_control[`PWAS_MODE_DLOW_HI:`PWAS_MODE_DLOW_LO] != 2'b00);
            else if (tick && (period_timer_count + 10'h001) >= duty_latched)
                pwm_level <= 1'b0;
        end
    end

    // pin values: shutdown overrides combinationally so it acts at once
    always @* begin
        next_a   = pwm_level ^ pol_a;
        next_b   = pwm_level ^ pol_b;
        next_a_z = pin_direction_bit[0];
        next_b_z = pin_direction_bit[1];
        if (shdn_active || pwm_restart) begin
            next_a   = (ss_a == `PWAS_SS_HIGH);
            next_b   = (ss_b == `PWAS_SS_HIGH);
            next_a_z = pin_direction_bit[0] | ss_a[1];
            next_b_z = pin_direction_bit[1] | ss_b[1];
        end
    end

    // data and enables; pins stay tri-state until software clears direction bits
    assign pwm_output_a_o    = next_a;
    assign pwm_output_b_o    = next_b;
    assign pwm_output_a_oe_n = next_a_z;
    assign pwm_output_b_oe_n = next_b_z;

    // read mux; unmapped offsets read zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (ce && psel && !penable && rd_en) begin
            case (paddr)
                `PWAS_OFS_PERIOD: prdata <= {24'h00_0000, period_register};
                `PWAS_OFS_MODE:   prdata <= {24'h00_0000, pwm_mode_control};
                `PWAS_OFS_DUTY:   prdata <= {24'h00_0000, duty_upper_bits};
                `PWAS_OFS_TCTRL:  prdata <= {24'h00_0000, period_timer_control};
                `PWAS_OFS_FLAGS:  prdata <= {31'h0000_0000, period_timer_flag};
                `PWAS_OFS_SHDN:   prdata <= {24'h00_0000, shdn_active,
                                             auto_shutdown_control[6:0]};
                `PWAS_OFS_DIR:    prdata <= {30'h0000_0000, pin_direction_bit};
                `PWAS_OFS_COUNT:  prdata <= {22'h00_0000, period_timer_count};
                default:          prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // pwas_core
`default_nettype wire

/* rtl/pwas_map.vh */
/*
 * register map, field positions, reset values and timing figures of the
 * pwm auto-shutdown controller; included by the core and prescaler design files of the block.
 */
`ifndef PWAS_MAP_VH
`define PWAS_MAP_VH

// register byte offsets on the apb bus
`define PWAS_OFS_PERIOD      12'h000
`define PWAS_OFS_MODE        12'h004
`define PWAS_OFS_DUTY        12'h008
`define PWAS_OFS_TCTRL       12'h00C
`define PWAS_OFS_FLAGS       12'h010
`define PWAS_OFS_SHDN        12'h014
`define PWAS_OFS_DIR         12'h018
`define PWAS_OFS_COUNT       12'h01C

// auto_shutdown_control fields
`define PWAS_SHDN_STATUS_BIT 7
`define PWAS_SHDN_SRC_HI     6
`define PWAS_SHDN_SRC_LO     4
`define PWAS_SHDN_A_HI       3
`define PWAS_SHDN_A_LO       2
`define PWAS_SHDN_B_HI       1
`define PWAS_SHDN_B_LO       0
`define PWAS_SHDN_RESET      8'h00

// pwm_mode_control fields: duty low bits 5:4, pwm enable 3:2, polarity 1:0
`define PWAS_MODE_DLOW_HI    5
`define PWAS_MODE_DLOW_LO    4
`define PWAS_MODE_EN_HI      3
`define PWAS_MODE_EN_LO      2
`define PWAS_MODE_POL_B      1
`define PWAS_MODE_POL_A      0
`define PWAS_MODE_RESET      8'h00

// period_timer_control fields: on bit 2, prescale 1:0
`define PWAS_TCTRL_ON_BIT    2
`define PWAS_TCTRL_PS_HI     1
`define PWAS_TCTRL_PS_LO     0
`define PWAS_TCTRL_RESET     8'h00

// other reset values; direction bits 1 mean input
`define PWAS_PERIOD_RESET    8'hFF
`define PWAS_DUTY_RESET      8'h00
`define PWAS_DIR_RESET       2'b11

// shutdown state field encodings
`define PWAS_SS_LOW          2'b00
`define PWAS_SS_HIGH         2'b01

// count of system clocks per timer tick, before prescale
`define PWAS_TICK_DIV        4

`endif

/* rtl/pwas_sync.v */
/*
 * two-flop synchroniser for one asynchronous level.
 * assumes pclk domain; first flop feeds only the second.
 */
`timescale 1ns/1ps
`default_nettype none
module pwas_sync (
    input  wire pclk,
    input  wire presetn,
    input  wire ce,
    input  wire d,
    output reg  q
);
    reg meta;

    // clock enable low freezes the chain like every other flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // pwas_sync
`default_nettype wire

/* rtl/pwas_prescale.v */
/*
 * period timer prescaler: emits a one-cycle tick every div*(1,4,16) clocks.
 * assumes pclk domain and a clock enable that freezes it during sleep.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pwas_map.vh"
module pwas_prescale #(
    parameter DIV = `PWAS_TICK_DIV
) (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       ce,
    input  wire       run,
    input  wire [1:0] ps,
    output wire       tick
);
    localparam [31:0] LIM_1  = DIV - 1;
    localparam [31:0] LIM_4  = DIV * 4 - 1;
    localparam [31:0] LIM_16 = DIV * 16 - 1;
    reg  [7:0] cnt;
    wire [7:0] limit;

    // 00 -> 1:1, 01 -> 1:4, 1x -> 1:16; div*16 must stay within the 8-bit counter
    assign limit = (ps == 2'b00) ? LIM_1[7:0] :
                   (ps == 2'b01) ? LIM_4[7:0] : LIM_16[7:0];
    assign tick  = run && (cnt >= limit);

    // counter rests while the timer is off so a restart begins clean
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt <= 8'h00;
        else if (ce) begin
            if (!run || tick)
                cnt <= 8'h00;
            else
                cnt <= cnt + 8'h01;
        end
    end
endmodule // pwas_prescale
`default_nettype wire

/* tb/pwas_load.sv */
/* pin model of the power-switch stages on outputs a and b.
   assumes pull-downs on both lines, so a floating pin reads as off. */
`timescale 1ns/1ps
`default_nettype none
module pwas_load (
    input  wire logic a_o,
    input  wire logic a_oe_n,
    input  wire logic b_o,
    input  wire logic b_oe_n,
    output logic      a_lvl,
    output logic      b_lvl
);
    // a released line falls to the pull-down, keeping the switch off
    assign a_lvl = a_oe_n ? 1'b0 : a_o;
    assign b_lvl = b_oe_n ? 1'b0 : b_o;
endmodule // pwas_load
`default_nettype wire

/* tb/pwas_props.sv */
/* assertions on the apb slave, sleep freeze and shutdown pins of pwas_core.
   assumes one pclk domain and apb writes as the only register updates. */
`timescale 1ns/1ps
`default_nettype none
`include "pwas_map.vh"
module pwas_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        shdn_pin_n,
    input wire logic        pwm_output_a_o,
    input wire logic        pwm_output_a_oe_n,
    input wire logic        pwm_output_b_o,
    input wire logic        pwm_output_b_oe_n
);
    logic [6:0] sp;
    logic [1:0] dir;
    logic [2:0] low;
    wire        wr = psel && penable && pwrite && ce;
    wire        shd = sp[6] && low >= 3'h2 && dir == 2'b00;
    // shadow fields; low counts pin-low edges, two of them fill the synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp <= 7'h00;
            dir <= 2'b11;
            low <= 3'h0;
        end else if (ce) begin
            if (wr && paddr == `PWAS_OFS_SHDN) sp <= pwdata[6:0];
            if (wr && paddr == `PWAS_OFS_DIR) dir <= pwdata[1:0];
            low <= shdn_pin_n ? 3'h0 : (low == 3'h7 ? low : low + 3'h1);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    reset_pins_a: assert property (
        $rose(presetn) |-> pwm_output_a_oe_n && pwm_output_b_oe_n && prdata == 32'h0000_0000)
        else $error("pins or read data not at reset state");
    sleep_hold_a: assert property (
        !ce |=> $stable(pwm_output_a_o) && $stable(pwm_output_a_oe_n) && $stable(pwm_output_b_o)
        && $stable(pwm_output_b_oe_n)) else $error("pins moved during sleep");
    sleep_ready_a: assert property (!ce |-> !pready) else $error("ready while asleep");
    access_ready_a: assert property (
        psel && penable && ce |-> pready && !pslverr) else $error("access not answered at once");
    shdn_a_a: assert property (shd |-> pwm_output_a_oe_n == sp[3]
        && (sp[3] || pwm_output_a_o == sp[2])) else $error("pin a not in shutdown state");
    shdn_b_a: assert property (shd |-> pwm_output_b_oe_n == sp[1]
        && (sp[1] || pwm_output_b_o == sp[0])) else $error("pin b not in shutdown state");
    shdn_status_a: assert property (
        psel && penable && !pwrite && paddr == `PWAS_OFS_SHDN && sp[6] && low >= 3'h3 |-> prdata[7])
        else $error("status bit clear during shutdown");
    level_hold_a: assert property (
        shd ##1 shd |-> $stable(pwm_output_a_oe_n) && $stable(pwm_output_b_oe_n))
        else $error("shutdown left while pin held low");
endmodule // pwas_props
bind pwas_core pwas_props u_props (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .shdn_pin_n, .pwm_output_a_o, .pwm_output_a_oe_n, .pwm_output_b_o,
    .pwm_output_b_oe_n);
`default_nettype wire

/* tb/pwas_core_tb.sv */
/* self-checking bench for pwas_core: apb tasks drive register sequences.
   assumes the pwas_load pin model and the bound pwas_props checker. */
`timescale 1ns/1ps
`default_nettype none
`include "pwas_map.vh"
module pwas_core_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        cmp_in = 1'b0;
    logic        shdn_pin_n = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] rd;
    logic [7:0]  s;
    wire         pready, pslverr, a_o, a_oe_n, b_o, b_oe_n, a_lvl, b_lvl;
    wire  [31:0] prdata;
    int          n_errors = 0;
    int          checked = 0;
    int          n;
    always #10 pclk = ~pclk;
    pwas_core #(.AUTO_RESTART(1)) dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .pslverr, .prdata, .cmp_in, .shdn_pin_n, .pwm_output_a_o(a_o), .pwm_output_a_oe_n(a_oe_n),
        .pwm_output_b_o(b_o), .pwm_output_b_oe_n(b_oe_n));
    pwas_load load (.a_o, .a_oe_n, .b_o, .b_oe_n, .a_lvl, .b_lvl);
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // request held until pready is seen high at an edge; a stuck slave ends the run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 64);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    task automatic rst_vals;
        chk("oe_n", 32'h0000_0003, {a_oe_n, b_oe_n});
        rdc(`PWAS_OFS_PERIOD, `PWAS_PERIOD_RESET, "period");
        rdc(`PWAS_OFS_MODE, `PWAS_MODE_RESET, "mode");
        rdc(`PWAS_OFS_DUTY, `PWAS_DUTY_RESET, "duty");
        rdc(`PWAS_OFS_TCTRL, `PWAS_TCTRL_RESET, "tctrl");
        rdc(`PWAS_OFS_SHDN, `PWAS_SHDN_RESET, "shdn");
        rdc(`PWAS_OFS_DIR, `PWAS_DIR_RESET, "dir");
    endtask
    task automatic poll_flag;
        n = 0;
        do begin
            apb(1'b0, `PWAS_OFS_FLAGS, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b1 && n < 1500);
        chk("flag", 1, rd[0]);
        if (rd[0] !== 1'b1) summarize();
    endtask
    initial begin
        wt(4);
        presetn <= 1'b1;
        rst_vals();
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        rdc(12'h020, 32'h0000_0000, "unmapped");
        // drivers off, period, mode, duty, then timer; drivers on after the flag
        apb(1'b1, `PWAS_OFS_DIR, 32'h0000_0003);
        apb(1'b1, `PWAS_OFS_PERIOD, 32'h0000_0001);
        apb(1'b1, `PWAS_OFS_MODE, 32'h0000_000C);
        apb(1'b1, `PWAS_OFS_DUTY, 32'h0000_0000);
        apb(1'b1, `PWAS_OFS_FLAGS, 32'h0000_0000);
        apb(1'b1, `PWAS_OFS_TCTRL, 32'h0000_0004);
        rdc(`PWAS_OFS_FLAGS, 32'h0000_0000, "flag early");
        poll_flag();
        chk("flag delay", 1, n >= 8);
        // empty and full duty against both polarities, drivers off while polarity moves
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, `PWAS_OFS_DIR, 32'h0000_0003);
            apb(1'b1, `PWAS_OFS_MODE, 32'h0000_000C + k);
            apb(1'b1, `PWAS_OFS_DUTY, k[1] ? 32'h0000_00FF : 32'h0000_0000);
            wt(80);
            apb(1'b1, `PWAS_OFS_DIR, 32'h0000_0000);
            wt(1);
            chk("pol a", k[0] ^ k[1], a_lvl);
        end
        // each pin source with every shutdown state on a and b
        for (int k = 0; k < 4; k++) begin
            s = 8'h40 + 8'(k * 20) + 8'(3 - k);
            apb(1'b1, `PWAS_OFS_SHDN, s);
            shdn_pin_n <= 1'b0;
            wt(3);
            chk("oe a", s[3], a_oe_n);
            chk("pin a", s[3] ? 1'b0 : s[2], a_lvl);
            chk("oe b", s[1], b_oe_n);
            chk("pin b", s[1] ? 1'b0 : s[0], b_lvl);
            apb(1'b1, `PWAS_OFS_SHDN, s);
            rdc(`PWAS_OFS_SHDN, s | 8'h80, "status");
            shdn_pin_n <= 1'b1;
            wt(2);
            rdc(`PWAS_OFS_SHDN, s | {s[4], 7'h00}, "held status");
            apb(1'b1, `PWAS_OFS_SHDN, s);
            wt(80);
            chk("resume", 32'h0000_0000, {a_oe_n, a_lvl});
        end
        // disabled codes ignore the pin, comparator codes latch until cleared
        for (int k = 0; k < 4; k++) begin
            s = 8'h04 + 8'(k * 16);
            apb(1'b1, `PWAS_OFS_SHDN, s);
            shdn_pin_n <= k[0];
            cmp_in <= cmp_in ^ k[0];
            wt(4);
            chk("src pin", k[0], {a_oe_n, a_lvl});
            rdc(`PWAS_OFS_SHDN, s | {k[0], 7'h00}, "src status");
            shdn_pin_n <= 1'b1;
            apb(1'b1, `PWAS_OFS_SHDN, s);
            rdc(`PWAS_OFS_SHDN, s, "src clear");
            wt(80);
        end
        // long period measured by the flag, then a short shutdown held to its end
        apb(1'b1, `PWAS_OFS_PERIOD, 32'h0000_00FF);
        apb(1'b1, `PWAS_OFS_SHDN, 32'h0000_0048);
        apb(1'b1, `PWAS_OFS_FLAGS, 32'h0000_0000);
        poll_flag();
        apb(1'b1, `PWAS_OFS_FLAGS, 32'h0000_0000);
        poll_flag();
        chk("period", 1, n > 1355 && n < 1370);
        shdn_pin_n <= 1'b0;
        wt(3);
        shdn_pin_n <= 1'b1;
        wt(4);
        rdc(`PWAS_OFS_SHDN, 32'h0000_0048, "auto restart");
        n = 0;
        while (a_oe_n !== 1'b0 && n < 5000) begin
            wt(1);
            n++;
        end
        chk("restart wait", 1, n > 3900 && n < 4100);
        if (n >= 5000) summarize();
        // sleep freezes the count; a running timer would move some fifty ticks
        apb(1'b0, `PWAS_OFS_COUNT, 32'h0000_0000);
        n = rd[9:0];
        ce <= 1'b0;
        wt(200);
        ce <= 1'b1;
        apb(1'b0, `PWAS_OFS_COUNT, 32'h0000_0000);
        chk("frozen", 1, 10'(rd[9:0] - 10'(n)) <= 10'h003);
        presetn <= 1'b0;
        wt(2);
        chk("oe in reset", 32'h0000_0003, {a_oe_n, b_oe_n});
        presetn <= 1'b1;
        rst_vals();
        // both slower prescale settings measured on the shortest period
        apb(1'b1, `PWAS_OFS_PERIOD, 32'h0000_0000);
        for (int k = 1; k < 3; k++) begin
            apb(1'b1, `PWAS_OFS_TCTRL, 32'h0000_0004 + k);
            apb(1'b1, `PWAS_OFS_FLAGS, 32'h0000_0000);
            poll_flag();
            apb(1'b1, `PWAS_OFS_FLAGS, 32'h0000_0000);
            poll_flag();
            chk("prescale", 1, k == 1 ? (n > 18 && n < 23) : (n > 81 && n < 88));
        end
        summarize();
    end
endmodule // pwas_core_tb
`default_nettype wire
